// ### verilog/sbit_pkg.sv
// Constants, register map and field layout of the sixteen-bit interval timer.
// How it works
// - Modes: internal timer, synchronised external counter, free external counter.
// - Interrupt on period match or on gate falling edge in gated mode.
// - Run bit one starts counting, zero stops and holds the count.
// - Idle-halt bit 13 set stops counting in idle; clear keeps counting.
// - Timer may keep running in idle or sleep, as configured.
// - Gate bit 6 counts only while gate high; ignored with external clock.
// - Prescale bits 5-4 divide by 256, 64, 8 or 1.
// - Sync bit 2 set stops external counting in sleep; the pin is always synchronised; ignored with internal clock.
// - All control bits reset to zero: stopped, internal, 1:1, no gating.
package sbit_pkg;

	// ----------------------------------------------------------------
	// Register byte offsets on the APB bus.
	// ----------------------------------------------------------------
	localparam int unsigned ADDR_W = 12;
	localparam logic [11:0] OFF_CTRL = 12'h000;
	localparam logic [11:0] OFF_COUNT = 12'h004;
	localparam logic [11:0] OFF_PERIOD = 12'h008;
	localparam logic [11:0] OFF_STATUS = 12'h00c;
	localparam logic [11:0] OFF_MASK = 12'h010;

	// ----------------------------------------------------------------
	// Control register field positions.
	// ----------------------------------------------------------------
	localparam int unsigned CTRL_RUN = 15;
	localparam int unsigned CTRL_IDLE_HALT = 13;
	localparam int unsigned CTRL_GATE = 6;
	localparam int unsigned CTRL_PS_HI = 5;
	localparam int unsigned CTRL_PS_LO = 4;
	localparam int unsigned CTRL_SYNC = 2;
	localparam int unsigned CTRL_SRC = 1;

	// ----------------------------------------------------------------
	// Status and mask bit positions.
	// ----------------------------------------------------------------
	localparam int unsigned IRQ_MATCH = 0;
	localparam int unsigned IRQ_GATE = 1;
	localparam int unsigned IRQ_W = 2;

	// ----------------------------------------------------------------
	// Reset values.
	// ----------------------------------------------------------------
	localparam logic [15:0] CTRL_RST = 16'h0000;
	localparam logic [15:0] COUNT_RST = 16'h0000;
	localparam logic [15:0] PERIOD_RST = 16'hffff;
	localparam logic [1:0] MASK_RST = 2'h0;

	// ----------------------------------------------------------------
	// Prescale codes and the last prescaler count of each ratio.
	// ----------------------------------------------------------------
	localparam logic [1:0] PS_DIV1 = 2'h0;
	localparam logic [1:0] PS_DIV8 = 2'h1;
	localparam logic [1:0] PS_DIV64 = 2'h2;
	localparam logic [1:0] PS_DIV256 = 2'h3;
	localparam logic [7:0] PS_LAST1 = 8'h00;
	localparam logic [7:0] PS_LAST8 = 8'h07;
	localparam logic [7:0] PS_LAST64 = 8'h3f;
	localparam logic [7:0] PS_LAST256 = 8'hff;

endpackage

// ### verilog/sbit_timer.sv
// Sixteen-bit interval timer with prescaler, gate and APB registers.
`timescale 1ns/1ps

module sbit_timer (
	// Clock, reset and clock enable.
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	// APB slave.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// External count and gate pin, asynchronous.
	input wire logic ext_count_pin,
	// Power-saving mode levels from the core clock domain.
	input wire logic idle_mode,
	input wire logic sleep_mode,
	// Level interrupt.
	output logic irq
);

	// ----------------------------------------------------------------
	// State of the whole block.
	// ----------------------------------------------------------------
	typedef struct packed {
		logic run_bit;
		logic idle_halt_bit;
		logic gated_accumulate_bit;
		logic [1:0] prescale_select;
		logic ext_clock_sync_bit;
		logic clock_source_bit;
		logic [15:0] count_register;
		logic [15:0] period_register;
		logic [7:0] presc;
		logic [1:0] status;
		logic [1:0] mask;
		logic pin_meta;
		logic pin_sync;
		logic pin_prev;
		logic ready;
		logic [31:0] rdata;
		logic slverr;
		logic irq;
	} sbit_state_t;

	sbit_state_t st_q;
	sbit_state_t st_d;

	// ----------------------------------------------------------------
	// Decoding helpers.
	// ----------------------------------------------------------------

	// Returns one when the address names a register of the block.
	function automatic logic sbit_addr_hit(input logic [11:0] a);
		sbit_addr_hit = (a == sbit_pkg::OFF_CTRL) ||
			(a == sbit_pkg::OFF_COUNT) ||
			(a == sbit_pkg::OFF_PERIOD) ||
			(a == sbit_pkg::OFF_STATUS) ||
			(a == sbit_pkg::OFF_MASK);
	endfunction

	// Last prescaler count for a prescale code.
	function automatic logic [7:0] sbit_ps_last(input logic [1:0] ps);
		case (ps)
			sbit_pkg::PS_DIV8: sbit_ps_last = sbit_pkg::PS_LAST8;
			sbit_pkg::PS_DIV64: sbit_ps_last = sbit_pkg::PS_LAST64;
			sbit_pkg::PS_DIV256: sbit_ps_last = sbit_pkg::PS_LAST256;
			default: sbit_ps_last = sbit_pkg::PS_LAST1;
		endcase
	endfunction

	// Gathers the control fields into their register layout.
	function automatic logic [15:0] sbit_ctrl_word(input sbit_state_t s);
		logic [15:0] w;
		w = 16'h0000;
		w[sbit_pkg::CTRL_RUN] = s.run_bit;
		w[sbit_pkg::CTRL_IDLE_HALT] = s.idle_halt_bit;
		w[sbit_pkg::CTRL_GATE] = s.gated_accumulate_bit;
		w[sbit_pkg::CTRL_PS_HI:sbit_pkg::CTRL_PS_LO] = s.prescale_select;
		w[sbit_pkg::CTRL_SYNC] = s.ext_clock_sync_bit;
		w[sbit_pkg::CTRL_SRC] = s.clock_source_bit;
		sbit_ctrl_word = w;
	endfunction

	// ----------------------------------------------------------------
	// Bus phase decode.
	// ----------------------------------------------------------------
	logic acc_first;
	logic acc_done;
	logic wr_done;
	logic wr_hit;
	logic [31:0] rd_word;

	// First access cycle latches read data; the next one completes.
	assign acc_first = psel & penable & ~st_q.ready;
	assign acc_done = psel & penable & st_q.ready;
	assign wr_done = acc_done & pwrite;
	assign wr_hit = wr_done & sbit_addr_hit(paddr);

	// Read multiplexer; unmapped addresses read as zero.
	always_comb begin
		rd_word = 32'h0000_0000;
		case (paddr)
			sbit_pkg::OFF_CTRL: rd_word[15:0] = sbit_ctrl_word(st_q);
			sbit_pkg::OFF_COUNT: rd_word[15:0] = st_q.count_register;
			sbit_pkg::OFF_PERIOD: rd_word[15:0] = st_q.period_register;
			sbit_pkg::OFF_STATUS: rd_word[1:0] = st_q.status;
			sbit_pkg::OFF_MASK: rd_word[1:0] = st_q.mask;
			default: rd_word = 32'h0000_0000;
		endcase
	end

	// ----------------------------------------------------------------
	// Count source selection and enables.
	// ----------------------------------------------------------------
	logic gate_mode;
	logic free_mode;
	logic run_ok;
	logic ext_rise;
	logic gate_fall;
	logic src_tick;
	logic pre_tick;
	logic match;

	// Gate only applies on the internal clock.
	assign gate_mode = st_q.gated_accumulate_bit & ~st_q.clock_source_bit;
	// Unsynchronised external counting is the mode that survives sleep.
	assign free_mode = st_q.clock_source_bit & ~st_q.ext_clock_sync_bit;

	// Run bit, idle halt and sleep together decide whether to count.
	// Sleep stops every mode but the unsynchronised pin counter, which
	// stands for the one mode that needs no core clock.
	assign run_ok = st_q.run_bit &
		~(idle_mode & st_q.idle_halt_bit) &
		~(sleep_mode & ~free_mode);

	// Edges of the synchronised pin; only the second stage is looked at.
	// The history stage rests low after reset like the idle pin, so no
	// false edge follows reset.
	assign ext_rise = st_q.pin_sync & ~st_q.pin_prev;
	assign gate_fall = gate_mode & st_q.run_bit &
		st_q.pin_prev & ~st_q.pin_sync;

	// Source tick: pin rising edge, gated clock, or every clock.
	// With the gate, the pin level and not its edge enables each clock.
	always_comb begin
		if (st_q.clock_source_bit) begin
			src_tick = ext_rise;
		end else if (gate_mode) begin
			src_tick = st_q.pin_sync;
		end else begin
			src_tick = 1'b1;
		end
	end

	// Prescaler terminal count gives the counter tick.
	assign pre_tick = run_ok & src_tick &
		(st_q.presc == sbit_ps_last(st_q.prescale_select));
	// Match compares the held count, so a new period acts at once.
	assign match = st_q.count_register == st_q.period_register;

	// ----------------------------------------------------------------
	// Next-state logic.
	// ----------------------------------------------------------------
	logic [1:0] events;
	logic [1:0] w1c;

	// Hardware events and software clears of the status flags.
	always_comb begin
		events = 2'h0;
		events[sbit_pkg::IRQ_MATCH] = pre_tick & match;
		events[sbit_pkg::IRQ_GATE] = gate_fall;
		w1c = 2'h0;
		if (wr_done && paddr == sbit_pkg::OFF_STATUS) begin
			w1c = pwdata[1:0];
		end
	end

	// Fills the next copy of the state.
	always_comb begin
		st_d = st_q;

		// Two-stage pin synchroniser and edge history.
		st_d.pin_meta = ext_count_pin;
		st_d.pin_sync = st_q.pin_meta;
		st_d.pin_prev = st_q.pin_sync;

		// Prescaler counts source ticks while running.
		// It holds its value while halted by idle or sleep.
		if (run_ok && src_tick) begin
			if (pre_tick) begin
				st_d.presc = 8'h00;
			end else begin
				st_d.presc = st_q.presc + 8'h01;
			end
		end

		// Counter wraps to zero on the tick after a match.
		if (pre_tick) begin
			if (match) begin
				st_d.count_register = 16'h0000;
			end else begin
				st_d.count_register = st_q.count_register + 16'h0001;
			end
		end

		// Register writes take effect at the completing edge. An unmapped
		// address changes nothing, so the decode is done once up front.
		if (wr_hit) begin
			case (paddr)
				sbit_pkg::OFF_CTRL: begin
					st_d.run_bit = pwdata[sbit_pkg::CTRL_RUN];
					st_d.idle_halt_bit =
						pwdata[sbit_pkg::CTRL_IDLE_HALT];
					st_d.gated_accumulate_bit =
						pwdata[sbit_pkg::CTRL_GATE];
					st_d.prescale_select =
						pwdata[sbit_pkg::CTRL_PS_HI:sbit_pkg::CTRL_PS_LO];
					st_d.ext_clock_sync_bit =
						pwdata[sbit_pkg::CTRL_SYNC];
					st_d.clock_source_bit =
						pwdata[sbit_pkg::CTRL_SRC];
					// A control write restarts the prescaler.
					st_d.presc = 8'h00;
				end
				sbit_pkg::OFF_COUNT: begin
					// Software load wins over a tick in the same cycle.
					st_d.count_register = pwdata[15:0];
					st_d.presc = 8'h00;
				end
				sbit_pkg::OFF_PERIOD: begin
					st_d.period_register = pwdata[15:0];
				end
				sbit_pkg::OFF_MASK: begin
					st_d.mask = pwdata[1:0];
				end
				default: begin
					st_d.mask = st_q.mask;
				end
			endcase
		end

		// Sticky flags: a new event wins over a clear in the same cycle.
		// A flag raised in the clearing cycle is therefore never lost.
		st_d.status = (st_q.status & ~w1c) | events;

		// Interrupt output follows the unmasked flags.
		st_d.irq = |(st_d.status & st_d.mask);

		// Bus answer: data and error latched, ready raised one cycle on.
		// Holding the answer in flip-flops costs one wait state but keeps
		// the read path away from the output pins.
		if (acc_first) begin
			st_d.ready = 1'b1;
			st_d.rdata = pwrite ? 32'h0000_0000 : rd_word;
			st_d.slverr = ~sbit_addr_hit(paddr);
		end else if (acc_done) begin
			st_d.ready = 1'b0;
			st_d.rdata = 32'h0000_0000;
			st_d.slverr = 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// State register; clock enable low freezes everything.
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			// Bus answer, synchroniser and flags all start cleared.
			st_q <= '0;
			// Control fields come from the control reset word.
			st_q.run_bit <= sbit_pkg::CTRL_RST[sbit_pkg::CTRL_RUN];
			st_q.idle_halt_bit <=
				sbit_pkg::CTRL_RST[sbit_pkg::CTRL_IDLE_HALT];
			st_q.gated_accumulate_bit <=
				sbit_pkg::CTRL_RST[sbit_pkg::CTRL_GATE];
			st_q.prescale_select <=
				sbit_pkg::CTRL_RST[sbit_pkg::CTRL_PS_HI:sbit_pkg::CTRL_PS_LO];
			st_q.ext_clock_sync_bit <=
				sbit_pkg::CTRL_RST[sbit_pkg::CTRL_SYNC];
			st_q.clock_source_bit <=
				sbit_pkg::CTRL_RST[sbit_pkg::CTRL_SRC];
			st_q.count_register <= sbit_pkg::COUNT_RST;
			st_q.period_register <= sbit_pkg::PERIOD_RST;
			st_q.mask <= sbit_pkg::MASK_RST;
		end else if (clk_en) begin
			st_q <= st_d;
		end
	end

	// ----------------------------------------------------------------
	// Outputs, each straight from the state register.
	// ----------------------------------------------------------------
	assign prdata = st_q.rdata;
	assign pready = st_q.ready;
	assign pslverr = st_q.slverr;
	assign irq = st_q.irq;

endmodule

// ### verification/sbit_pin_model.sv
// Far-side model that drives the external count and gate pin.
`timescale 1ns/1ps
module sbit_pin_model (
	// Clock that paces the pin.
	input wire logic pclk,
	// Pin level seen by the timer.
	output logic ext_count_pin
);
	// The pin rests low between pulse trains.
	initial ext_count_pin = 1'h0;
	// Gives n rising edges, each high for hi cycles, then low for five, or for four after the last.
	task automatic pulse(input int n, input int hi);
		for (int i = 0; i < n; i++) begin
			@(posedge pclk);
			ext_count_pin <= 1'h1;
			repeat (hi) @(posedge pclk);
			ext_count_pin <= 1'h0;
			repeat (4) @(posedge pclk);
		end
	endtask
endmodule

// ### verification/sbit_timer_sva.sv
// Checks of bus timing, register fields and interrupt at the timer ports.
`timescale 1ns/1ps
module sbit_timer_chk (
	// Clock, reset and enable.
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	// APB slave signals.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Interrupt output.
	input wire logic irq
);
	// ------------------------------------------------------------
	// Shared clocking and sequences.
	// ------------------------------------------------------------
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Access cycle that still waits for its answer.
	sequence acc_wait;
		clk_en && psel && penable && !pready;
	endsequence
	// Completed read.
	sequence rd_done;
		pready && psel && !pwrite;
	endsequence
	// Completed write that masks every source.
	sequence mask_off;
		pready && pwrite && paddr == sbit_pkg::OFF_MASK
			&& pwdata[1:0] == 2'h0;
	endsequence
	// ------------------------------------------------------------
	// Assertions.
	// ------------------------------------------------------------
	chk_ready_answer: assert property (acc_wait |=> pready)
		else $error("pready late");
	chk_ready_single: assert property (pready |=> !pready)
		else $error("pready too long");
	chk_ready_cause: assert property (!penable |=> !pready)
		else $error("pready without access");
	chk_rdata_idle: assert property (!pready |-> prdata == 32'h0)
		else $error("prdata not zero");
	chk_err_unmapped: assert property
		((acc_wait ##0 paddr > 12'h010) |=> pslverr)
		else $error("pslverr missing");
	chk_err_mapped: assert property
		((acc_wait ##0 paddr[1:0] == 2'h0 && paddr <= 12'h010) |=> !pslverr)
		else $error("pslverr on mapped register");
	chk_ctrl_reserved: assert property
		((rd_done ##0 paddr == sbit_pkg::OFF_CTRL)
		|-> (prdata & 32'hffff_5f89) == 32'h0)
		else $error("reserved control bits set");
	chk_irq_masked: assert property (mask_off |-> ##2 !irq [*3])
		else $error("irq while masked");
	chk_err_ready: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
endmodule

// ### verification/testbench.sv
// Self-checking bench of the interval timer and its register port.
`timescale 1ns/1ps
module testbench;
	// ------------------------------------------------------------
	// Signals, counters and tables.
	// ------------------------------------------------------------
	logic pclk, presetn, clk_en, psel, penable, pwrite, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd, keep;
	logic [15:0] e;
	logic pready, pslverr, ext_count_pin, idle_mode, sleep_mode, irq;
	int errors, n_tests;
	int sh [4] = '{0, 3, 6, 8};
	logic [31:0] mc [4] = '{32'h8006, 32'h8002, 32'h8006, 32'h8046};
	logic sl [4] = '{1'h0, 1'h1, 1'h1, 1'h0};
	logic [31:0] me [4] = '{32'h5, 32'h5, 32'h0, 32'h5};
	typedef struct {logic w; logic [11:0] a; logic [31:0] d, x; logic e;}
		sbit_row_t;
	sbit_row_t rows [12] = '{
		'{1'h0, 12'h000, 32'h0, 32'h0, 1'h0},
		'{1'h0, 12'h004, 32'h0, 32'h0, 1'h0},
		'{1'h0, 12'h008, 32'h0, 32'hffff, 1'h0},
		'{1'h0, 12'h00c, 32'h0, 32'h0, 1'h0},
		'{1'h0, 12'h010, 32'h0, 32'h0, 1'h0},
		'{1'h1, 12'h000, 32'hffff_7fff, 32'h0, 1'h0},
		'{1'h0, 12'h000, 32'h0, 32'h2076, 1'h0},
		'{1'h1, 12'h008, 32'hffff_1234, 32'h0, 1'h0},
		'{1'h0, 12'h008, 32'h0, 32'h1234, 1'h0},
		'{1'h1, 12'h010, 32'hffff_ffff, 32'h0, 1'h0},
		'{1'h0, 12'h010, 32'h0, 32'h3, 1'h0},
		'{1'h0, 12'h014, 32'h0, 32'h0, 1'h1}};
	sbit_timer sbit_timer_i (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.ext_count_pin(ext_count_pin), .idle_mode(idle_mode),
		.sleep_mode(sleep_mode), .irq(irq));
	sbit_pin_model sbit_pin_model_i (.pclk(pclk),
		.ext_count_pin(ext_count_pin));
	// ------------------------------------------------------------
	// Tasks.
	// ------------------------------------------------------------
	task automatic test_done;
		$display("errors %0d tests %0d", errors, n_tests);
		if (errors == 0 && n_tests > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	// Counts a comparison and reports a mismatch.
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// One transfer: setup, then access until pready is sampled high.
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int k;
		k = 0;
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'h1 && k < 20);
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		if (k >= 20) begin
			errors++;
			test_done();
		end
		@(posedge pclk);
	endtask
	// Clears count and flags, then writes the control word last.
	task automatic start(input logic [31:0] c);
		apb(1'h1, 12'h004, 32'h0);
		apb(1'h1, 12'h00c, 32'h3);
		apb(1'h1, 12'h000, c);
	endtask
	// Stops the timer, then reads the held count.
	task automatic stop_rd;
		apb(1'h1, 12'h000, 32'h0);
		apb(1'h0, 12'h004, 32'h0);
	endtask
	// ------------------------------------------------------------
	// Clock and main sequence.
	// ------------------------------------------------------------
	initial begin
		pclk = 1'h0;
		forever #4 pclk = ~pclk;
	end
	initial begin
		{errors, n_tests} = 0;
		{presetn, clk_en, psel, penable, pwrite} = 5'h08;
		{paddr, pwdata, idle_mode, sleep_mode} = 46'h0;
		repeat (16) @(posedge pclk);
		presetn <= 1'h1;
		@(posedge pclk);
		foreach (rows[i]) begin
			apb(rows[i].w, rows[i].a, rows[i].d);
			if (!rows[i].w) cmp(rd, rows[i].x);
			cmp({31'h0, err}, {31'h0, rows[i].e});
		end
		apb(1'h1, 12'h008, 32'hffff);
		for (int p = 0; p < 4; p++) begin
			start(32'h8000 | (p << 4));
			repeat (511) @(posedge pclk);
			stop_rd();
			keep = rd;
			e = 16'h203 >> sh[p];
			cmp(rd, {16'h0, e});
			apb(1'h0, 12'h004, 32'h0);
			cmp(rd, keep);
		end
		apb(1'h1, 12'h008, 32'h3);
		apb(1'h1, 12'h010, 32'h1);
		start(32'h8000);
		repeat (30) @(posedge pclk);
		stop_rd();
		cmp(rd, 32'h2);
		apb(1'h0, 12'h00c, 32'h0);
		cmp(rd, 32'h1);
		cmp({31'h0, irq}, 32'h1);
		apb(1'h1, 12'h010, 32'h0);
		repeat (2) @(posedge pclk);
		cmp({31'h0, irq}, 32'h0);
		apb(1'h1, 12'h008, 32'hffff);
		idle_mode <= 1'h1;
		start(32'ha000);
		repeat (40) @(posedge pclk);
		stop_rd();
		cmp(rd, 32'h0);
		start(32'h8000);
		repeat (40) @(posedge pclk);
		stop_rd();
		cmp({31'h0, rd[15:0] > 16'h28}, 32'h1);
		idle_mode <= 1'h0;
		for (int m = 0; m < 4; m++) begin
			sleep_mode <= sl[m];
			start(mc[m]);
			sbit_pin_model_i.pulse(5, 4);
			stop_rd();
			cmp(rd, me[m]);
			apb(1'h0, 12'h00c, 32'h0);
			cmp(rd, 32'h0);
		end
		sleep_mode <= 1'h0;
		start(32'h8040);
		sbit_pin_model_i.pulse(1, 20);
		stop_rd();
		cmp({31'h0, rd[15:0] > 16'h12 && rd[15:0] < 16'h16}, 32'h1);
		apb(1'h0, 12'h00c, 32'h0);
		cmp(rd, 32'h2);
		// Clock enable low freezes the count along with all other state.
		start(32'h8000);
		repeat (10) @(posedge pclk);
		clk_en <= 1'h0;
		repeat (20) @(posedge pclk);
		clk_en <= 1'h1;
		stop_rd();
		cmp(rd, 32'he);
		// Reset in mid-run returns control, period and count to their reset values.
		apb(1'h1, 12'h008, 32'h0055);
		apb(1'h1, 12'h000, 32'ha076);
		presetn <= 1'h0;
		repeat (2) @(posedge pclk);
		presetn <= 1'h1;
		@(posedge pclk);
		apb(1'h0, 12'h000, 32'h0);
		cmp(rd, 32'h0);
		apb(1'h0, 12'h008, 32'h0);
		cmp(rd, 32'hffff);
		apb(1'h0, 12'h004, 32'h0);
		cmp(rd, 32'h0);
		test_done();
	end
endmodule
// Attaches the port checker to every timer instance.
bind sbit_timer sbit_timer_chk sbit_timer_chk_i (.pclk(pclk),
	.presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .irq(irq));
